// file: rtl/fpci_bridge.sv
/*
 * Bridge end of the fast bus: target for host cycles, master for the
 * internal and external requesters, posting queue and delayed reads.
 * Assumes the host end arbitrates the fast bus and that the local
 * port returns read data one cycle after o_loc_req.
 */
// Behaviour
// - Answer host cycles as a bus target.
// - Master DMA cycles only on an idle bus.
// - Act as initiator for internal requesters.
// - Positive window decode, optional subtractive claim.
// - Drive parity out, check parity in.
// - Config space reached by type 1 cycles.
// - Claim fast or with subtractive delay.
// - Post memory writes, finish them later.
// - Retry non-local cycles as delayed transactions.
// - Host cycles carry one data phase.
// - Accept type 0 and type 1 configuration.
// - Forward external memory cycles to system memory.
// - Disconnect external bursts at cache line ends.
// - Refuse external I/O and config cycles.
// - Legacy masters forward memory cycles only.
// - Serve at most two external masters.
// - Fixed priority over eight requesters.
// - Bus grant comes from the host end.
`default_nettype none
module fpci_bridge #(
	parameter logic [31:0] WIN_MASK = 32'hFFFF_0000,
	parameter logic [31:0] SYSMEM_TOP = 32'h1000_0000,
	parameter logic [4:0] DEV_NUM = 5'h01,
	parameter int LINE_BYTES = 32,
	parameter int POST_DEPTH = 4
) (
	input wire logic i_sys_clk,
	input wire logic i_sys_rst,
	fpci_if.bridge bus,
	input wire logic i_other_claim,
	output logic o_loc_req,
	output logic o_loc_wr,
	output logic [31:0] o_loc_addr,
	output logic [31:0] o_loc_wdata,
	input wire logic [31:0] i_loc_rdata,
	output logic o_dn_req,
	output logic [3:0] o_dn_cmd,
	output logic [31:0] o_dn_addr,
	output logic [31:0] o_dn_wdata,
	input wire logic i_dn_done,
	input wire logic [31:0] i_dn_rdata,
	input wire logic [fpci_pkg::N_REQ-1:0] i_mreq,
	output logic [fpci_pkg::N_REQ-1:0] o_mgnt,
	input wire logic i_mvalid,
	input wire logic [3:0] i_mcmd,
	input wire logic [31:0] i_maddr,
	input wire logic [31:0] i_mwdata,
	input wire logic i_mlast,
	output logic o_mack,
	output logic o_mdisc,
	output logic o_mrej,
	output logic [31:0] o_mrdata
);
	localparam int N = fpci_pkg::N_REQ;
	localparam int PW = (POST_DEPTH > 1) ? $clog2(POST_DEPTH) : 1;
	localparam int LW = $clog2(LINE_BYTES);
	localparam logic [PW:0] PFULL = (PW+1)'(POST_DEPTH);

	typedef enum logic [1:0] {T_IDLE, T_SUB, T_LOC, T_END} tst_e;
	typedef enum logic [1:0] {M_IDLE, M_BEAT, M_REQ, M_BUS} mst_e;
	typedef struct packed {
		logic loc;
		logic [31:0] a;
		logic [31:0] d;
	} post_s;
	typedef struct packed {
		tst_e t_st;
		logic [3:0] cnt;
		logic devsel;
		logic trdy;
		logic stop;
		logic rpar;
		logic [31:0] rdata;
		logic [3:0] cmd;
		logic [31:0] addr;
		logic [31:0] wdata;
		logic [3:0][31:0] cfg;
		post_s [POST_DEPTH-1:0] pq;
		logic [PW-1:0] wp;
		logic [PW-1:0] rp;
		logic [PW:0] pcnt;
		logic dly_busy;
		logic dly_done;
		logic [3:0] dly_cmd;
		logic [31:0] dly_addr;
		logic [31:0] dly_wdata;
		logic [31:0] dly_rdata;
		logic dn_req;
		logic dn_dly;
		logic [3:0] dn_cmd;
		logic [31:0] dn_addr;
		logic [31:0] dn_wdata;
		logic loc_req;
		logic loc_wr;
		logic [31:0] loc_addr;
		logic [31:0] loc_wdata;
		mst_e m_st;
		logic [N-1:0] gnt;
		logic m_req;
		logic m_frame;
		logic m_apar;
		logic m_dpar;
		logic mlast;
		logic mack;
		logic mdisc;
		logic mrej;
		logic [3:0] m_cmd;
		logic [31:0] m_addr;
		logic [31:0] m_wdata;
		logic [31:0] mrdata;
	} st_s;

	st_s s_ff;
	st_s nxt_s;
	logic [N-1:0] win;
	logic [3:0] c_cmd;
	logic [31:0] c_addr;
	logic [31:0] c_wdata;
	logic c_wr;
	logic c_mem;
	logic c_io;
	logic c_cfg;
	logic own;
	logic hit;
	logic act;
	logic push;
	logic pop;
	logic bad;
	logic [1:0] idx;
	logic [31:0] set_st;
	logic [31:0] clr_st;

	fixed_prio_arb #(.N(N)) u_arb (
		.i_req(i_mreq),
		.o_gnt(win)
	);

	always_comb
	begin
		nxt_s = s_ff;
		c_cmd = (s_ff.t_st == T_IDLE) ? bus.t_cmd : s_ff.cmd;
		c_addr = (s_ff.t_st == T_IDLE) ? bus.t_addr : s_ff.addr;
		c_wdata = (s_ff.t_st == T_IDLE) ? bus.t_wdata : s_ff.wdata;
		c_wr = c_cmd[0];
		c_mem = fpci_pkg::is_mem(c_cmd);
		c_io = (c_cmd == fpci_pkg::CMD_IORD) || (c_cmd == fpci_pkg::CMD_IOWR);
		c_cfg = (c_cmd == fpci_pkg::CMD_CRD) || (c_cmd == fpci_pkg::CMD_CWR);
		own = c_cfg && ((c_addr[1:0] == fpci_pkg::CFG_TYPE0) ||
			(c_addr[1:0] == fpci_pkg::CFG_TYPE1 &&
			c_addr[fpci_pkg::BUS_LSB +: 8] == 8'h00 &&
			c_addr[fpci_pkg::DEV_LSB +: 5] == DEV_NUM));
		hit = (s_ff.t_st == T_IDLE) && ((c_mem && (c_addr & WIN_MASK) ==
			(s_ff.cfg[fpci_pkg::CFG_MEMWIN] & WIN_MASK)) ||
			(c_io && (c_addr & WIN_MASK) ==
			(s_ff.cfg[fpci_pkg::CFG_IOWIN] & WIN_MASK)) || own);
		idx = c_addr[fpci_pkg::IDX_LSB +: 2];
		act = 1'b0;
		push = 1'b0;
		pop = 1'b0;
		set_st = 32'h0000_0000;
		clr_st = 32'h0000_0000;
		nxt_s.devsel = 1'b0;
		nxt_s.trdy = 1'b0;
		nxt_s.stop = 1'b0;
		nxt_s.loc_req = 1'b0;
		nxt_s.mack = 1'b0;
		nxt_s.mdisc = 1'b0;
		nxt_s.mrej = 1'b0;
		case (s_ff.t_st)
			T_IDLE:
				if (bus.t_frame)
				begin
					nxt_s.cmd = bus.t_cmd;
					nxt_s.addr = bus.t_addr;
					nxt_s.wdata = bus.t_wdata;
					if (bus.t_apar != fpci_pkg::par(bus.t_addr, bus.t_cmd) ||
						(c_wr && bus.t_dpar != fpci_pkg::par(bus.t_wdata, 4'h0)))
						set_st[fpci_pkg::STAT_TPERR] = 1'b1;
					if (hit)
						act = 1'b1;
					else if (s_ff.cfg[fpci_pkg::CFG_CTRL][fpci_pkg::CTRL_SUB_EN] &&
						!i_other_claim)
					begin
						nxt_s.t_st = T_SUB;
						nxt_s.cnt = fpci_pkg::SUB_WAIT;
					end
					else
						nxt_s.t_st = T_END;
				end
			T_SUB:
				if (i_other_claim)
					nxt_s.t_st = T_END;
				else if (s_ff.cnt == 4'h0)
					act = 1'b1;
				else
					nxt_s.cnt = s_ff.cnt - 4'h1;
			T_LOC:
				if (!s_ff.loc_req)
				begin
				nxt_s.devsel = 1'b1;
				nxt_s.trdy = 1'b1;
				nxt_s.rdata = i_loc_rdata;
				nxt_s.rpar = fpci_pkg::par(i_loc_rdata, 4'h0);
				nxt_s.t_st = T_END;
			end
			T_END:
				if (!bus.t_frame)
					nxt_s.t_st = T_IDLE;
			default:
				nxt_s.t_st = T_IDLE;
		endcase
		if (act)
		begin
			nxt_s.t_st = T_END;
			nxt_s.devsel = 1'b1;
			if (c_mem && c_wr)
			begin
				push = (s_ff.pcnt != PFULL);
				nxt_s.trdy = push;
				nxt_s.stop = !push;
			end
			else if (own)
			begin
				nxt_s.trdy = 1'b1;
				nxt_s.rdata = s_ff.cfg[idx];
				nxt_s.rpar = fpci_pkg::par(s_ff.cfg[idx], 4'h0);
				if (c_wr && idx == fpci_pkg::CFG_STAT)
					clr_st = c_wdata;
				else if (c_wr)
					nxt_s.cfg[idx] = c_wdata;
			end
			else if (hit && s_ff.pcnt == '0)
			begin
				nxt_s.devsel = 1'b0;
				nxt_s.loc_req = 1'b1;
				nxt_s.loc_wr = c_wr;
				nxt_s.loc_addr = c_addr;
				nxt_s.loc_wdata = c_wdata;
				nxt_s.t_st = T_LOC;
			end
			else if (!hit && s_ff.dly_done && s_ff.dly_cmd == c_cmd &&
				s_ff.dly_addr == c_addr)
			begin
				nxt_s.trdy = 1'b1;
				nxt_s.rdata = s_ff.dly_rdata;
				nxt_s.rpar = fpci_pkg::par(s_ff.dly_rdata, 4'h0);
				nxt_s.dly_done = 1'b0;
			end
			else
			begin
				nxt_s.stop = 1'b1;
				if (!hit && !s_ff.dly_busy && !s_ff.dly_done &&
					s_ff.pcnt == '0)
				begin
					nxt_s.dly_busy = 1'b1;
					nxt_s.dly_cmd = c_cmd;
					nxt_s.dly_addr = c_addr;
					nxt_s.dly_wdata = c_wdata;
				end
			end
		end
		if (push)
		begin
			nxt_s.pq[s_ff.wp] = '{loc: hit, a: c_addr, d: c_wdata};
			nxt_s.wp = s_ff.wp + 1'b1;
		end
		if (s_ff.dn_req && i_dn_done)
		begin
			nxt_s.dn_req = 1'b0;
			if (s_ff.dn_dly)
			begin
				nxt_s.dly_busy = 1'b0;
				nxt_s.dly_done = 1'b1;
				nxt_s.dly_rdata = i_dn_rdata;
			end
			else
				pop = 1'b1;
		end
		else if (s_ff.pcnt != '0 && s_ff.pq[s_ff.rp].loc)
		begin
			if (s_ff.t_st == T_IDLE && !bus.t_frame)
			begin
				pop = 1'b1;
				nxt_s.loc_req = 1'b1;
				nxt_s.loc_wr = 1'b1;
				nxt_s.loc_addr = s_ff.pq[s_ff.rp].a;
				nxt_s.loc_wdata = s_ff.pq[s_ff.rp].d;
			end
		end
		else if (!s_ff.dn_req && (s_ff.pcnt != '0 || s_ff.dly_busy))
		begin
			nxt_s.dn_req = 1'b1;
			nxt_s.dn_dly = (s_ff.pcnt == '0);
			nxt_s.dn_cmd = (s_ff.pcnt == '0) ? s_ff.dly_cmd :
				fpci_pkg::CMD_MWR;
			nxt_s.dn_addr = (s_ff.pcnt == '0) ? s_ff.dly_addr :
				s_ff.pq[s_ff.rp].a;
			nxt_s.dn_wdata = (s_ff.pcnt == '0) ? s_ff.dly_wdata :
				s_ff.pq[s_ff.rp].d;
		end
		if (pop)
			nxt_s.rp = s_ff.rp + 1'b1;
		nxt_s.pcnt = s_ff.pcnt + (PW+1)'(push) - (PW+1)'(pop);
		bad = (((s_ff.gnt & fpci_pkg::EXT_MASK) != '0) &&
			!(fpci_pkg::is_mem(i_mcmd) && i_maddr < SYSMEM_TOP)) ||
			(((s_ff.gnt & fpci_pkg::LEG_MASK) != '0) &&
			!fpci_pkg::is_mem(i_mcmd));
		case (s_ff.m_st)
			M_IDLE:
				if (i_mreq != '0)
				begin
					nxt_s.gnt = win;
					nxt_s.m_st = M_BEAT;
				end
			M_BEAT:
				if (s_ff.mack)
					nxt_s.m_st = M_BEAT;
				else if (i_mvalid && bad)
				begin
					nxt_s.mrej = 1'b1;
					nxt_s.gnt = '0;
					nxt_s.m_st = M_IDLE;
				end
				else if (i_mvalid)
				begin
					nxt_s.m_cmd = i_mcmd;
					nxt_s.m_addr = i_maddr;
					nxt_s.m_wdata = i_mwdata;
					nxt_s.mlast = i_mlast;
					nxt_s.m_apar = fpci_pkg::par(i_maddr, i_mcmd);
					nxt_s.m_dpar = fpci_pkg::par(i_mwdata, 4'h0);
					nxt_s.m_req = 1'b1;
					nxt_s.m_st = M_REQ;
				end
				else if ((i_mreq & s_ff.gnt) == '0)
				begin
					nxt_s.gnt = '0;
					nxt_s.m_st = M_IDLE;
				end
			M_REQ:
				if (bus.m_gnt && s_ff.t_st == T_IDLE && !bus.t_frame)
				begin
					nxt_s.m_frame = 1'b1;
					nxt_s.m_st = M_BUS;
				end
			M_BUS:
				if (bus.m_trdy)
				begin
					nxt_s.m_frame = 1'b0;
					nxt_s.m_req = 1'b0;
					nxt_s.mack = 1'b1;
					nxt_s.mrdata = bus.m_rdata;
					if (!s_ff.m_cmd[0] &&
						bus.m_rpar != fpci_pkg::par(bus.m_rdata, 4'h0))
						set_st[fpci_pkg::STAT_MPERR] = 1'b1;
					nxt_s.m_st = M_BEAT;
					if (s_ff.mlast || (&s_ff.m_addr[LW-1:2]))
					begin
						nxt_s.mdisc = !s_ff.mlast;
						nxt_s.gnt = '0;
						nxt_s.m_st = M_IDLE;
					end
				end
			default:
				nxt_s.m_st = M_IDLE;
		endcase
		nxt_s.cfg[fpci_pkg::CFG_STAT] =
			(s_ff.cfg[fpci_pkg::CFG_STAT] & ~clr_st) | set_st;
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (i_sys_rst)
		begin
			s_ff <= '0;
			s_ff.cfg[fpci_pkg::CFG_CTRL] <= fpci_pkg::CTRL_RST;
		end
		else
			s_ff <= nxt_s;
	end

	assign bus.t_devsel = s_ff.devsel;
	assign bus.t_trdy = s_ff.trdy;
	assign bus.t_stop = s_ff.stop;
	assign bus.t_rdata = s_ff.rdata;
	assign bus.t_rpar = s_ff.rpar;
	assign bus.m_req = s_ff.m_req;
	assign bus.m_frame = s_ff.m_frame;
	assign bus.m_cmd = s_ff.m_cmd;
	assign bus.m_addr = s_ff.m_addr;
	assign bus.m_wdata = s_ff.m_wdata;
	assign bus.m_apar = s_ff.m_apar;
	assign bus.m_dpar = s_ff.m_dpar;
	assign o_loc_req = s_ff.loc_req;
	assign o_loc_wr = s_ff.loc_wr;
	assign o_loc_addr = s_ff.loc_addr;
	assign o_loc_wdata = s_ff.loc_wdata;
	assign o_dn_req = s_ff.dn_req;
	assign o_dn_cmd = s_ff.dn_cmd;
	assign o_dn_addr = s_ff.dn_addr;
	assign o_dn_wdata = s_ff.dn_wdata;
	assign o_mgnt = s_ff.gnt;
	assign o_mack = s_ff.mack;
	assign o_mdisc = s_ff.mdisc;
	assign o_mrej = s_ff.mrej;
	assign o_mrdata = s_ff.mrdata;
endmodule : fpci_bridge
`default_nettype wire

// file: rtl/fpci_pkg.sv
/*
 * Shared constants for the fast-bus bridge and its host end.
 * Assumes both ends are compiled after this package.
 */
`default_nettype none
package fpci_pkg;
	localparam int N_REQ = 8;
	localparam logic [3:0] CMD_IORD = 4'h2;
	localparam logic [3:0] CMD_IOWR = 4'h3;
	localparam logic [3:0] CMD_MRD = 4'h6;
	localparam logic [3:0] CMD_MWR = 4'h7;
	localparam logic [3:0] CMD_CRD = 4'hA;
	localparam logic [3:0] CMD_CWR = 4'hB;
	localparam logic [1:0] CFG_TYPE0 = 2'h0;
	localparam logic [1:0] CFG_TYPE1 = 2'h1;
	localparam int BUS_LSB = 16;
	localparam int DEV_LSB = 11;
	localparam int IDX_LSB = 2;
	localparam logic [1:0] CFG_MEMWIN = 2'h0;
	localparam logic [1:0] CFG_IOWIN = 2'h1;
	localparam logic [1:0] CFG_CTRL = 2'h2;
	localparam logic [1:0] CFG_STAT = 2'h3;
	localparam int CTRL_SUB_EN = 0;
	localparam logic [31:0] CTRL_RST = 32'h0000_0001;
	localparam int STAT_TPERR = 0;
	localparam int STAT_MPERR = 1;
	localparam logic [3:0] SUB_WAIT = 4'h2;
	localparam logic [3:0] ABORT_CYC = 4'h6;
	localparam logic [3:0] RETRY_GAP = 4'h2;
	localparam logic [N_REQ-1:0] EXT_MASK = 8'h60;
	localparam logic [N_REQ-1:0] LEG_MASK = 8'h80;

	function automatic logic par(input logic [31:0] d, input logic [3:0] c);
		return ^{d, c};
	endfunction : par

	function automatic logic is_mem(input logic [3:0] c);
		return (c == CMD_MRD) || (c == CMD_MWR);
	endfunction : is_mem
endpackage : fpci_pkg
`default_nettype wire

// file: rtl/fpci_if.sv
/*
 * Wires between the host end and the bridge end of the fast bus.
 * Assumes one clock shared by both ends; the bench joins them.
 */
`default_nettype none
interface fpci_if;
	logic t_frame;
	logic [3:0] t_cmd;
	logic [31:0] t_addr;
	logic [31:0] t_wdata;
	logic t_apar;
	logic t_dpar;
	logic t_devsel;
	logic t_trdy;
	logic t_stop;
	logic [31:0] t_rdata;
	logic t_rpar;
	logic m_req;
	logic m_gnt;
	logic m_frame;
	logic [3:0] m_cmd;
	logic [31:0] m_addr;
	logic [31:0] m_wdata;
	logic m_apar;
	logic m_dpar;
	logic m_trdy;
	logic [31:0] m_rdata;
	logic m_rpar;

	modport bridge (
		input t_frame, t_cmd, t_addr, t_wdata, t_apar, t_dpar,
		output t_devsel, t_trdy, t_stop, t_rdata, t_rpar,
		output m_req, m_frame, m_cmd, m_addr, m_wdata, m_apar, m_dpar,
		input m_gnt, m_trdy, m_rdata, m_rpar
	);
	modport host (
		output t_frame, t_cmd, t_addr, t_wdata, t_apar, t_dpar,
		input t_devsel, t_trdy, t_stop, t_rdata, t_rpar,
		input m_req, m_frame, m_cmd, m_addr, m_wdata, m_apar, m_dpar,
		output m_gnt, m_trdy, m_rdata, m_rpar
	);
endinterface : fpci_if
`default_nettype wire

// file: rtl/fixed_prio_arb.sv
/*
 * Fixed-priority picker: bit 0 is the highest priority request.
 * Assumes the caller registers the one-hot result.
 */
`default_nettype none
module fixed_prio_arb #(
	parameter int N = 8
) (
	input wire logic [N-1:0] i_req,
	output logic [N-1:0] o_gnt
);
	logic [N:0] higher;

	assign higher[0] = 1'b0;
	for (genvar i = 0; i < N; i++)
	begin : g_bit
		assign o_gnt[i] = i_req[i] & ~higher[i];
		assign higher[i+1] = higher[i] | i_req[i];
	end
endmodule : fixed_prio_arb
`default_nettype wire

// file: rtl/fpci_host.sv
/*
 * Host end of the fast bus: issues single-phase cycles, repeats
 * retried ones, arbitrates the bridge and serves its memory cycles.
 * Assumes the bridge end from fpci_bridge on the same interface.
 */
`default_nettype none
module fpci_host #(
	parameter int MEM_WORDS = 16
) (
	input wire logic i_sys_clk,
	input wire logic i_sys_rst,
	fpci_if.host bus,
	input wire logic i_cmd_valid,
	input wire logic [3:0] i_cmd,
	input wire logic [31:0] i_addr,
	input wire logic [31:0] i_wdata,
	output logic o_cmd_ready,
	output logic o_rsp_valid,
	output logic o_rsp_abort,
	output logic [31:0] o_rdata,
	output logic o_perr
);
	localparam int MW = $clog2(MEM_WORDS);

	typedef enum logic [1:0] {H_IDLE, H_WAIT, H_GAP} hst_e;
	typedef struct packed {
		hst_e st;
		logic [3:0] cnt;
		logic ready;
		logic frame;
		logic [3:0] cmd;
		logic [31:0] addr;
		logic [31:0] wdata;
		logic apar;
		logic dpar;
		logic rsp;
		logic abort;
		logic [31:0] rdata;
		logic perr;
		logic gnt;
		logic served;
		logic m_trdy;
		logic [31:0] m_rdata;
		logic m_rpar;
		logic [MEM_WORDS-1:0][31:0] mem;
	} st_s;

	st_s s_ff;
	st_s nxt_s;
	logic take;
	logic is_cfg;
	logic [31:0] a_out;
	logic [MW-1:0] mi;

	always_comb
	begin
		nxt_s = s_ff;
		take = s_ff.ready && i_cmd_valid;
		is_cfg = (i_cmd == fpci_pkg::CMD_CRD) || (i_cmd == fpci_pkg::CMD_CWR);
		a_out = is_cfg ? {8'h00, i_addr[23:2], fpci_pkg::CFG_TYPE1} :
			i_addr;
		mi = bus.m_addr[MW+1:2];
		nxt_s.rsp = 1'b0;
		nxt_s.abort = 1'b0;
		nxt_s.perr = 1'b0;
		nxt_s.m_trdy = 1'b0;
		case (s_ff.st)
			H_IDLE:
				if (take)
				begin
					nxt_s.cmd = i_cmd;
					nxt_s.addr = a_out;
					nxt_s.wdata = i_wdata;
					nxt_s.apar = fpci_pkg::par(a_out, i_cmd);
					nxt_s.dpar = fpci_pkg::par(i_wdata, 4'h0);
					nxt_s.frame = 1'b1;
					nxt_s.cnt = fpci_pkg::ABORT_CYC;
					nxt_s.st = H_WAIT;
				end
			H_WAIT:
				if (bus.t_trdy)
				begin
					nxt_s.frame = 1'b0;
					nxt_s.rsp = 1'b1;
					nxt_s.rdata = bus.t_rdata;
					nxt_s.perr = !s_ff.cmd[0] &&
						bus.t_rpar != fpci_pkg::par(bus.t_rdata, 4'h0);
					nxt_s.st = H_IDLE;
				end
				else if (bus.t_stop)
				begin
					nxt_s.frame = 1'b0;
					nxt_s.cnt = fpci_pkg::RETRY_GAP;
					nxt_s.st = H_GAP;
				end
				else if (s_ff.cnt == 4'h0)
				begin
					nxt_s.frame = 1'b0;
					nxt_s.rsp = 1'b1;
					nxt_s.abort = 1'b1;
					nxt_s.st = H_IDLE;
				end
				else
					nxt_s.cnt = s_ff.cnt - 4'h1;
			H_GAP:
				if (s_ff.cnt == 4'h0)
				begin
					nxt_s.frame = 1'b1;
					nxt_s.cnt = fpci_pkg::ABORT_CYC;
					nxt_s.st = H_WAIT;
				end
				else
					nxt_s.cnt = s_ff.cnt - 4'h1;
			default:
				nxt_s.st = H_IDLE;
		endcase
		nxt_s.gnt = bus.m_req &&
			(s_ff.gnt || (s_ff.st == H_IDLE && !take));
		if (!bus.m_frame)
			nxt_s.served = 1'b0;
		else if (!s_ff.served)
		begin
			nxt_s.served = 1'b1;
			nxt_s.m_trdy = 1'b1;
			if (bus.m_cmd[0])
				nxt_s.mem[mi] = bus.m_wdata;
			nxt_s.m_rdata = s_ff.mem[mi];
			nxt_s.m_rpar = fpci_pkg::par(s_ff.mem[mi], 4'h0);
			if (bus.m_apar != fpci_pkg::par(bus.m_addr, bus.m_cmd) ||
				(bus.m_cmd[0] &&
				bus.m_dpar != fpci_pkg::par(bus.m_wdata, 4'h0)))
				nxt_s.perr = 1'b1;
		end
		nxt_s.ready = (nxt_s.st == H_IDLE) && !nxt_s.gnt && !bus.m_req;
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (i_sys_rst)
			s_ff <= '0;
		else
			s_ff <= nxt_s;
	end

	assign bus.t_frame = s_ff.frame;
	assign bus.t_cmd = s_ff.cmd;
	assign bus.t_addr = s_ff.addr;
	assign bus.t_wdata = s_ff.wdata;
	assign bus.t_apar = s_ff.apar;
	assign bus.t_dpar = s_ff.dpar;
	assign bus.m_gnt = s_ff.gnt;
	assign bus.m_trdy = s_ff.m_trdy;
	assign bus.m_rdata = s_ff.m_rdata;
	assign bus.m_rpar = s_ff.m_rpar;
	assign o_cmd_ready = s_ff.ready;
	assign o_rsp_valid = s_ff.rsp;
	assign o_rsp_abort = s_ff.abort;
	assign o_rdata = s_ff.rdata;
	assign o_perr = s_ff.perr;
endmodule : fpci_host
`default_nettype wire

// file: bench/fpci_assertions.sv
/*
 * Checker for the fast-bus wires between the host and bridge ends.
 * Assumes the bench instantiates it beside the joining interface.
 */
`default_nettype none
module fpci_assertions (
	input wire logic i_sys_clk,
	input wire logic i_sys_rst,
	input wire logic t_frame,
	input wire logic [3:0] t_cmd,
	input wire logic [31:0] t_addr,
	input wire logic [31:0] t_wdata,
	input wire logic t_apar,
	input wire logic t_dpar,
	input wire logic t_devsel,
	input wire logic t_trdy,
	input wire logic t_stop,
	input wire logic [31:0] t_rdata,
	input wire logic t_rpar,
	input wire logic m_req,
	input wire logic m_gnt,
	input wire logic m_frame,
	input wire logic [3:0] m_cmd,
	input wire logic [31:0] m_addr,
	input wire logic [31:0] m_wdata,
	input wire logic m_apar,
	input wire logic m_dpar,
	input wire logic m_trdy
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_sys_rst);
	claim_outcome_a: assert property (t_devsel |-> t_trdy ^ t_stop)
		else $error("claim outcome");
	answer_claimed_a: assert property ((t_trdy || t_stop) |-> t_devsel && t_frame)
		else $error("unclaimed answer");
	host_parity_a: assert property (t_frame |->
		t_apar == ^{t_addr, t_cmd} && t_dpar == ^t_wdata)
		else $error("host parity");
	read_parity_a: assert property (t_trdy |-> t_rpar == ^t_rdata)
		else $error("read parity");
	single_phase_a: assert property ((t_trdy || t_stop) |=> !t_frame)
		else $error("frame held");
	master_parity_a: assert property (m_frame |->
		m_apar == ^{m_addr, m_cmd} && m_dpar == ^m_wdata)
		else $error("beat parity");
	beat_granted_a: assert property ($rose(m_frame) |-> $past(m_gnt) && m_req)
		else $error("beat ungranted");
	beat_held_a: assert property (m_frame && !m_trdy |=>
		m_frame && $stable(m_addr) && $stable(m_cmd))
		else $error("beat unstable");
	beat_ends_a: assert property (m_trdy |=> !m_frame)
		else $error("master beat kept after ready");
	no_preempt_a: assert property (!(t_frame && m_frame))
		else $error("master beat during host cycle");
	cover property (t_devsel && t_stop);
	cover property (t_devsel && t_trdy);
	cover property (m_trdy);
endmodule : fpci_assertions
`default_nettype wire

// file: bench/fast_pci_south_bridge_port_bench.sv
/*
 * Self-checking bench: host and bridge ends joined by the interface.
 * Assumes default parameters; the bench serves local and downstream.
 */
`default_nettype none
module fast_pci_south_bridge_port_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_sys_clk, i_sys_rst, i_other_claim, i_dn_done, i_mvalid, i_mlast;
	logic i_cmd_valid, o_loc_req, o_loc_wr, o_dn_req, o_mack, o_mdisc, o_mrej;
	logic o_cmd_ready, o_rsp_valid, o_rsp_abort, o_perr;
	logic [31:0] i_loc_rdata, i_dn_rdata, i_maddr, i_mwdata, i_addr, i_wdata;
	logic [31:0] o_loc_addr, o_loc_wdata, o_dn_addr, o_dn_wdata, o_mrdata;
	logic [31:0] o_rdata, dn_val, dn_addr_s, dn_wd_s, rd_s, mrd_s, a, d;
	logic [3:0] i_mcmd, i_cmd, o_dn_cmd, dn_cmd_s;
	logic [fpci_pkg::N_REQ-1:0] i_mreq, o_mgnt;
	logic abort_s, ack_s, rej_s, disc_s;
	logic [64:0] loc_q[$], exp_q[$];
	int err_total, samples_checked, n_dn, dn_wait, n;

	fpci_if fpci_if_i ();
	fpci_bridge fpci_bridge_i (.i_sys_clk, .i_sys_rst, .bus(fpci_if_i.bridge),
		.i_other_claim, .o_loc_req, .o_loc_wr, .o_loc_addr, .o_loc_wdata,
		.i_loc_rdata, .o_dn_req, .o_dn_cmd, .o_dn_addr, .o_dn_wdata, .i_dn_done,
		.i_dn_rdata, .i_mreq, .o_mgnt, .i_mvalid, .i_mcmd, .i_maddr, .i_mwdata,
		.i_mlast, .o_mack, .o_mdisc, .o_mrej, .o_mrdata);
	fpci_host fpci_host_i (.i_sys_clk, .i_sys_rst, .bus(fpci_if_i.host),
		.i_cmd_valid, .i_cmd, .i_addr, .i_wdata, .o_cmd_ready, .o_rsp_valid,
		.o_rsp_abort, .o_rdata, .o_perr);
	fpci_assertions fpci_assertions_i (.i_sys_clk, .i_sys_rst,
		.t_frame(fpci_if_i.t_frame), .t_cmd(fpci_if_i.t_cmd),
		.t_addr(fpci_if_i.t_addr), .t_wdata(fpci_if_i.t_wdata),
		.t_apar(fpci_if_i.t_apar), .t_dpar(fpci_if_i.t_dpar),
		.t_devsel(fpci_if_i.t_devsel), .t_trdy(fpci_if_i.t_trdy),
		.t_stop(fpci_if_i.t_stop), .t_rdata(fpci_if_i.t_rdata),
		.t_rpar(fpci_if_i.t_rpar), .m_req(fpci_if_i.m_req),
		.m_gnt(fpci_if_i.m_gnt), .m_frame(fpci_if_i.m_frame),
		.m_cmd(fpci_if_i.m_cmd), .m_addr(fpci_if_i.m_addr),
		.m_wdata(fpci_if_i.m_wdata), .m_apar(fpci_if_i.m_apar),
		.m_dpar(fpci_if_i.m_dpar), .m_trdy(fpci_if_i.m_trdy));

	function automatic logic [31:0] loc_fn(input logic [31:0] x);
		return {x[15:0], x[31:16]} ^ 32'hA5A5_0F0F;
	endfunction : loc_fn

	function automatic logic [31:0] cfg_a(input logic [1:0] idx);
		return {16'h0000, 5'h01, 3'h0, 4'h0, idx, 2'h0};
	endfunction : cfg_a

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : test_done

	task automatic check(input string what, input logic [64:0] e,
		input logic [64:0] g);
		samples_checked++;
		if (g !== e)
		begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", what, e, g);
		end
	endtask : check

	task automatic host_op(input logic [3:0] c, input logic [31:0] ad,
		input logic [31:0] wd);
		int k;
		k = 0;
		do begin @(posedge i_sys_clk); k++; end
		while (o_cmd_ready !== 1'b1 && k < 500);
		i_cmd_valid <= 1'b1;
		i_cmd <= c;
		i_addr <= ad;
		i_wdata <= wd;
		@(posedge i_sys_clk);
		i_cmd_valid <= 1'b0;
		do begin @(posedge i_sys_clk); k++; end
		while (o_rsp_valid !== 1'b1 && k < 500);
		rd_s = o_rdata;
		abort_s = o_rsp_abort;
		check("host answer", 1'b1, k < 500);
	endtask : host_op

	task automatic mbeat(input int r, input logic [3:0] c,
		input logic [31:0] ad, input logic [31:0] wd, input logic last);
		int k;
		k = 0;
		i_mreq[r] <= 1'b1;
		do begin @(posedge i_sys_clk); k++; end
		while (o_mgnt[r] !== 1'b1 && k < 100);
		i_mvalid <= 1'b1;
		i_mcmd <= c;
		i_maddr <= ad;
		i_mwdata <= wd;
		i_mlast <= last;
		do begin @(posedge i_sys_clk); k++; end
		while (o_mack !== 1'b1 && o_mrej !== 1'b1 && k < 200);
		{ack_s, rej_s, disc_s, mrd_s} = {o_mack, o_mrej, o_mdisc, o_mrdata};
		i_mvalid <= 1'b0;
		if (last || rej_s || disc_s)
			i_mreq[r] <= 1'b0;
		@(posedge i_sys_clk);
	endtask : mbeat

	task automatic mcase(input int r, input logic [3:0] c,
		input logic [31:0] ad, input logic rej);
		mbeat(r, c, ad, $urandom(), 1'b1);
		check("ack reject", {~rej, rej}, {ack_s, rej_s});
	endtask : mcase

	initial
	begin
		i_sys_clk = 1'b0;
		forever #5 i_sys_clk = ~i_sys_clk;
	end

	always @(posedge i_sys_clk)
	begin
		if (o_loc_req === 1'b1)
		begin
			i_loc_rdata <= loc_fn(o_loc_addr);
			loc_q.push_back({o_loc_wr, o_loc_addr, o_loc_wdata});
		end
		else
			i_loc_rdata <= ~i_loc_rdata;
		if (o_dn_req === 1'b1 && i_dn_done !== 1'b1 && dn_wait == 3)
		begin
			i_dn_done <= 1'b1;
			i_dn_rdata <= dn_val;
			{dn_cmd_s, dn_addr_s, dn_wd_s} = {o_dn_cmd, o_dn_addr, o_dn_wdata};
			dn_wait = 0;
			n_dn++;
		end
		else
		begin
			i_dn_done <= 1'b0;
			i_dn_rdata <= ~dn_val;
			if (o_dn_req === 1'b1 && i_dn_done !== 1'b1)
				dn_wait++;
		end
		if (o_perr === 1'b1)
			check("host parity flag", 1'b0, o_perr);
	end

	initial
	begin
		#(10 * 30000);
		err_total++;
		$display("[ERR] run time expected done seen hang");
		test_done();
	end

	initial
	begin
		{i_sys_rst, i_other_claim, i_mvalid, i_mlast, i_cmd_valid} = 5'h10;
		{i_loc_rdata, i_dn_rdata, i_maddr, i_mwdata, i_addr} = '0;
		{i_wdata, i_mcmd, i_cmd, i_mreq, i_dn_done, dn_val} = '0;
		{err_total, samples_checked, n_dn, dn_wait} = '0;
		void'($urandom(32'h9448));
		repeat (12) @(posedge i_sys_clk);
		i_sys_rst <= 1'b0;
		host_op(fpci_pkg::CMD_CRD, cfg_a(fpci_pkg::CFG_CTRL), 32'h0);
		check("ctrl reset", fpci_pkg::CTRL_RST, rd_s);
		host_op(fpci_pkg::CMD_CRD, cfg_a(fpci_pkg::CFG_STAT), 32'h0);
		check("status", 32'h0, rd_s);
		host_op(fpci_pkg::CMD_CWR, cfg_a(fpci_pkg::CFG_MEMWIN), 32'h0002_0000);
		host_op(fpci_pkg::CMD_CWR, cfg_a(fpci_pkg::CFG_IOWIN), 32'h0003_0000);
		host_op(fpci_pkg::CMD_CRD, cfg_a(fpci_pkg::CFG_MEMWIN), 32'h0);
		check("memory window", 32'h0002_0000, rd_s);
		dn_val = $urandom();
		host_op(fpci_pkg::CMD_CRD, 32'h0001_0800, 32'h0);
		check("remote config", {dn_cmd_s, dn_val}, {4'hA, rd_s});
		$display("test config done");
		loc_q.delete();
		for (int i = 0; i < 4; i++)
		begin
			a = 32'h0002_0000 | ($urandom() & 32'h0000_FFFC);
			d = $urandom();
			exp_q.push_back({1'b1, a, d});
			host_op(fpci_pkg::CMD_MWR, a, d);
			check("posted answer", 1'b0, abort_s);
		end
		for (n = 0; n < 200 && loc_q.size() < 4; n++)
			@(posedge i_sys_clk);
		for (int i = 0; i < 4; i++)
			check("local write", exp_q[i], loc_q[i]);
		host_op(fpci_pkg::CMD_MRD, 32'h0002_0010, 32'h0);
		check("window read", loc_fn(32'h0002_0010), rd_s);
		host_op(fpci_pkg::CMD_IORD, 32'h0003_0008, 32'h0);
		check("io read", loc_fn(32'h0003_0008), rd_s);
		$display("test target done");
		a = 32'h3000_0000 | ($urandom() & 32'h0000_0FFC);
		dn_val = $urandom();
		host_op(fpci_pkg::CMD_MRD, a, 32'h0);
		check("delayed read", {dn_cmd_s, dn_addr_s, dn_val}, {4'h6, a, rd_s});
		d = $urandom();
		n = n_dn;
		host_op(fpci_pkg::CMD_MWR, 32'h3000_0100, d);
		repeat (60) @(posedge i_sys_clk);
		check("drained write", {n + 1, dn_cmd_s, dn_wd_s}, {n_dn, 4'h7, d});
		i_other_claim <= 1'b1;
		host_op(fpci_pkg::CMD_MRD, 32'h3000_0200, 32'h0);
		check("claimed elsewhere", 1'b1, abort_s);
		i_other_claim <= 1'b0;
		host_op(fpci_pkg::CMD_CWR, cfg_a(fpci_pkg::CFG_CTRL), 32'h0);
		host_op(fpci_pkg::CMD_MRD, 32'h3000_0300, 32'h0);
		check("no subtractive", 1'b1, abort_s);
		$display("test delayed done");
		d = $urandom();
		mbeat(0, fpci_pkg::CMD_MWR, 32'h0000_0040, d, 1'b1);
		mbeat(1, fpci_pkg::CMD_MRD, 32'h0000_0040, 32'h0, 1'b1);
		check("master read", d, mrd_s);
		mcase(6, fpci_pkg::CMD_IORD, 32'h0000_0010, 1'b1);
		mcase(5, fpci_pkg::CMD_CRD, 32'h0000_0010, 1'b1);
		mcase(6, fpci_pkg::CMD_MWR, 32'h2000_0000, 1'b1);
		mcase(5, fpci_pkg::CMD_MRD, 32'h0000_0044, 1'b0);
		mcase(7, fpci_pkg::CMD_IOWR, 32'h0000_0010, 1'b1);
		mcase(7, fpci_pkg::CMD_MWR, 32'h0000_0048, 1'b0);
		for (int w = $urandom_range(7, 0); w < 8; w++)
		begin
			d = $urandom();
			mbeat(5, fpci_pkg::CMD_MWR, 32'h0000_0080 + 4 * w, d, 1'b0);
			check("line end", {1'b1, w == 7}, {ack_s, disc_s});
		end
		mbeat(2, fpci_pkg::CMD_MRD, 32'h0000_009C, 32'h0, 1'b1);
		check("burst data", d, mrd_s);
		$display("test master done");
		for (int k = 0; k < 7; k++)
		begin
			for (n = 0; n < 50 && o_mgnt !== '0; n++)
				@(posedge i_sys_clk);
			i_mreq <= ($urandom() | (8'h01 << k)) & (8'hFF << k);
			for (n = 0; n < 50 && o_mgnt === '0; n++)
				@(posedge i_sys_clk);
			check("grant", 8'h01 << k, o_mgnt);
			i_mreq <= '0;
		end
		$display("test priority done");
		test_done();
	end
endmodule : fast_pci_south_bridge_port_bench
`default_nettype wire
